// >>> logic/csq_pkg.sv
// Constants, register map and types of the channel sequencer and conversion timer
package csq_pkg;
  // Channel set and counter widths
  localparam int NCH    = 4;
  localparam int CHW    = 2;
  localparam int CNT_W  = 20;
  localparam int FS_W   = 11;
  localparam int FILT_W = 4;
  localparam int SET_W  = 3;
  localparam int REP_W  = 8;

  // Register byte offsets on the APB
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_STATUS   = 8'h04;
  localparam logic [3:0] OFF_CFG_PAGE = 4'h1;   // 0x10..0x1C, one word per channel

  // Channel configuration word layout
  localparam int CFG_FS_LSB   = 0;
  localparam int CFG_FILT_LSB = 12;
  localparam int CFG_SET_LSB  = 16;
  localparam int CFG_REP_LSB  = 20;
  localparam int CFG_EN_BIT   = 31;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  localparam int CTRL_RUN_BIT = 0;

  // Status word layout
  localparam int ST_CNT_LSB   = 0;
  localparam int ST_CH_LSB    = 16;
  localparam int ST_PH_LSB    = 18;
  localparam int ST_FIRST_BIT = 20;
  localparam int ST_DPP_BIT   = 21;

  // Filter type encodings
  localparam logic [3:0] FT_SINC4     = 4'h0;
  localparam logic [3:0] FT_SINC4_AVG = 4'h1;
  localparam logic [3:0] FT_SINC3     = 4'h2;
  localparam logic [3:0] FT_SINC3_R60 = 4'h3;
  localparam logic [3:0] FT_SINC3_AVG = 4'h4;
  localparam logic [3:0] FT_POST1     = 4'h5;
  localparam logic [3:0] FT_POST2     = 4'h6;
  localparam logic [3:0] FT_POST3     = 4'h7;
  localparam logic [3:0] FT_POST4     = 4'h8;

  // Timing in main-clock cycles
  localparam int SETTLE_BASE = 32;
  localparam int TCNV_MUL    = 32;
  localparam int AVG_LEN     = 8;
  localparam int ORD_SINC4   = 4;
  localparam int ORD_SINC3   = 3;
  localparam int TCNV_POST1  = 2944;
  localparam int TCNV_POST2  = 3200;
  localparam int TCNV_POST3  = 3968;
  localparam int TCNV_POST4  = 4736;
  localparam int DPP_SHORT   = 28;
  localparam int DPP_LONG    = 62;
  localparam int DPP_POST    = 69;
  localparam int FS_SHORT_MAX = 1;

  // Sequencer phases
  typedef enum logic [1:0] {PH_IDLE, PH_SETTLE, PH_CONV} csq_phase_t;
endpackage

// >>> logic/csq_down_counter.sv
// Loadable down-counter that marks the last cycle of a programmed interval
`timescale 1ns/1ps
module csq_down_counter
  import csq_pkg::*;
#(
  parameter int W = CNT_W
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Load port
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  // State
  output logic              busy,
  output logic              done
);
  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;

  // Count down to zero after a load
  assign next_cnt = load ? load_val : (busy ? cnt - W'(1) : cnt);
  assign busy = (cnt != '0);
  assign done = (cnt == W'(1)); // Not gated by load, which the caller derives from done

  // Counter register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end
endmodule

// >>> logic/csq_sequencer.sv
// Channel sequencer and conversion timing controller with APB register access
// How it works
// - Several enabled channels are cycled in turn
// - Channels may repeat conversions or convert once
// - Repeat count zero gives one sample
// - Switch channel when conversion ends, not postprocessing
// - Channel change resets modulator, filter, switches mux
// - Settling never shorter than 32 cycles
// - Settling is 32 shifted left by code
// - Sinc4 first conversion lasts four periods
// - Sinc3 and reject option: three periods
// - Averaging and post filters: one period
// - Period is 32, 352 or 320 times select
// - Post filters use fixed periods 2944 to 4736
// - Averaging stage averages eight sinc outputs
// - First result: settle, ideal conversion, postprocess
// - Later results come one period apart
// - Postprocess 28 or 62 cycles by select, always 62 with averaging
// - Post filter postprocess is 69 cycles
`timescale 1ns/1ps
module csq_sequencer
  import csq_pkg::*;
(
  // Clock and reset
  input  wire logic           CORE_CLK,
  input  wire logic           RST_N,
  // APB slave
  input  wire logic           PSEL,
  input  wire logic           PENABLE,
  input  wire logic           PWRITE,
  input  wire logic [7:0]     PADDR,
  input  wire logic [31:0]    PWDATA,
  output logic      [31:0]    PRDATA,
  output logic                PREADY,
  output logic                PSLVERR,
  // Front end control
  output logic                MOD_RESET,
  output logic      [CHW-1:0] INPUT_CROSSPOINT_MUX,
  // Result events
  output logic                DATA_READY,
  output logic      [CHW-1:0] DATA_CH
);
  // Interval functions
  function automatic logic [CNT_W-1:0] tcnv_of(input logic [3:0] ft, input logic [FS_W-1:0] fs);
    int t;
    t = TCNV_MUL * int'(fs);
    unique case (ft)
      FT_SINC4_AVG: t = (ORD_SINC4 + AVG_LEN - 1) * TCNV_MUL * int'(fs);
      FT_SINC3_AVG: t = (ORD_SINC3 + AVG_LEN - 1) * TCNV_MUL * int'(fs);
      FT_POST1:     t = TCNV_POST1;
      FT_POST2:     t = TCNV_POST2;
      FT_POST3:     t = TCNV_POST3;
      FT_POST4:     t = TCNV_POST4;
      default:      t = TCNV_MUL * int'(fs);
    endcase
    if (t < 1) begin
      t = 1;
    end
    return CNT_W'(t);
  endfunction

  function automatic logic [CNT_W-1:0] ideal_of(input logic [3:0] ft, input logic [FS_W-1:0] fs);
    int t;
    t = int'(tcnv_of(ft, fs));
    if (ft == FT_SINC4) begin
      t = ORD_SINC4 * t;
    end else if (ft == FT_SINC3 || ft == FT_SINC3_R60) begin
      t = ORD_SINC3 * t;
    end
    return CNT_W'(t);
  endfunction

  function automatic logic [CNT_W-1:0] dpp_of(input logic [3:0] ft, input logic [FS_W-1:0] fs);
    int t;
    if (ft >= FT_POST1) begin
      t = DPP_POST;
    end else if (ft == FT_SINC4_AVG || ft == FT_SINC3_AVG || int'(fs) > FS_SHORT_MAX) begin
      t = DPP_LONG;
    end else begin
      t = DPP_SHORT;
    end
    return CNT_W'(t);
  endfunction

  function automatic logic [CHW-1:0] next_en(input logic [NCH-1:0] en, input logic [CHW-1:0] from);
    logic [CHW-1:0] pick;
    logic [CHW-1:0] idx;
    logic           found;
    pick  = from;
    found = 1'b0;
    for (int i = 1; i <= NCH; i++) begin
      idx = from + CHW'(i);
      if (!found && en[idx]) begin
        pick  = idx;
        found = 1'b1;
      end
    end
    return pick;
  endfunction

  // Registers and state
  logic [31:0]      cfg [NCH];
  logic             run;
  csq_phase_t       phase;
  logic [CHW-1:0]   cur_ch;
  logic [REP_W-1:0] rep_left;
  logic             first;
  logic [CHW-1:0]   dpp_ch;
  logic [15:0]      drdy_cnt;

  // Field views of the configuration words
  logic [NCH-1:0]   en_vec;
  logic [3:0]       ft_cur;
  logic [FS_W-1:0]  fs_cur;
  logic [3:0]       ft_tgt;
  logic [FS_W-1:0]  fs_tgt;
  logic [SET_W-1:0] set_tgt;
  logic [REP_W-1:0] rep_tgt;

  for (genvar g = 0; g < NCH; g++) begin : g_en
    assign en_vec[g] = cfg[g][CFG_EN_BIT];
  end

  // Sequencing events
  logic             any_en;
  logic [CHW-1:0]   nxt_ch;
  logic [CHW-1:0]   tgt_ch;
  logic             main_done;
  logic             main_busy;
  logic             main_load;
  logic [CNT_W-1:0] main_val;
  logic             dpp_done;
  logic             dpp_busy;
  logic             idle_go;
  logic             settle_done;
  logic             conv_done;
  logic             more_rep;
  logic             stay;
  logic             chan_switch;
  logic             chan_start;
  logic             stop;
  logic [CNT_W-1:0] settle_len;

  assign any_en      = |en_vec;
  assign nxt_ch      = next_en(en_vec, cur_ch);
  assign idle_go     = (phase == PH_IDLE) && run && any_en;
  assign settle_done = (phase == PH_SETTLE) && main_done;
  assign conv_done   = (phase == PH_CONV) && main_done;
  assign more_rep    = (rep_left != '0);
  assign stay        = conv_done && run && en_vec[cur_ch] && (more_rep || nxt_ch == cur_ch);
  assign chan_switch = conv_done && run && any_en && !stay;
  assign chan_start  = idle_go || chan_switch;
  assign stop        = conv_done && !stay && !chan_switch;
  assign tgt_ch      = idle_go ? next_en(en_vec, CHW'(NCH - 1)) : nxt_ch;

  assign ft_cur  = cfg[cur_ch][CFG_FILT_LSB +: FILT_W];
  assign fs_cur  = cfg[cur_ch][CFG_FS_LSB +: FS_W];
  assign ft_tgt  = cfg[tgt_ch][CFG_FILT_LSB +: FILT_W];
  assign fs_tgt  = cfg[tgt_ch][CFG_FS_LSB +: FS_W];
  assign set_tgt = cfg[tgt_ch][CFG_SET_LSB +: SET_W];
  assign rep_tgt = cfg[tgt_ch][CFG_REP_LSB +: REP_W];

  // Settling interval of the channel being entered
  assign settle_len = CNT_W'(SETTLE_BASE) << set_tgt;

  // Main interval: settle, then ideal first conversion, then settled periods
  assign main_load = chan_start || settle_done || stay;
  assign main_val  = chan_start ? settle_len : (settle_done ? ideal_of(ft_cur, fs_cur) : tcnv_of(ft_cur, fs_cur));

  csq_down_counter #(.W(CNT_W)) u_main (
    .clk      (CORE_CLK),
    .rst_n    (RST_N),
    .load     (main_load),
    .load_val (main_val),
    .busy     (main_busy),
    .done     (main_done)
  );

  // Postprocessing runs after every conversion, overlapping the next settle or repeat conversion
  csq_down_counter #(.W(CNT_W)) u_dpp (
    .clk      (CORE_CLK),
    .rst_n    (RST_N),
    .load     (conv_done),
    .load_val (dpp_of(ft_cur, fs_cur)),
    .busy     (dpp_busy),
    .done     (dpp_done)
  );

  // Sequencer state
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      phase    <= PH_IDLE;
      cur_ch   <= '0;
      rep_left <= '0;
      first    <= 1'b0;
    end else begin
      if (chan_start) begin
        phase    <= PH_SETTLE;
        cur_ch   <= tgt_ch;
        rep_left <= rep_tgt;
      end else if (settle_done) begin
        phase <= PH_CONV;
        first <= 1'b1;
      end else if (stop) begin
        phase <= PH_IDLE;
      end
      if (stay && more_rep) begin
        rep_left <= rep_left - REP_W'(1);
      end
      if (conv_done) begin
        first <= 1'b0;
      end
    end
  end

  // Front end and result outputs
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      MOD_RESET            <= 1'b0;
      INPUT_CROSSPOINT_MUX <= '0;
      DATA_READY           <= 1'b0;
      DATA_CH              <= '0;
      dpp_ch               <= '0;
      drdy_cnt             <= '0;
    end else begin
      MOD_RESET  <= chan_start;
      DATA_READY <= dpp_done;
      if (chan_start) begin
        INPUT_CROSSPOINT_MUX <= tgt_ch;
      end
      if (conv_done) begin
        dpp_ch <= cur_ch;
      end
      if (dpp_done) begin
        DATA_CH  <= dpp_ch;
        drdy_cnt <= drdy_cnt + 16'h0001;
      end
    end
  end

  // APB decode
  logic        acc;
  logic        setup;
  logic        hit_ctrl;
  logic        hit_stat;
  logic        hit_cfg;
  logic        hit;
  logic [CHW-1:0] cfg_idx;
  logic [31:0] status_word;
  logic [31:0] rd_mux;

  assign acc      = PSEL && PENABLE;
  assign setup    = PSEL && !PENABLE;
  assign hit_ctrl = (PADDR == OFF_CTRL);
  assign hit_stat = (PADDR == OFF_STATUS);
  assign hit_cfg  = (PADDR[7:4] == OFF_CFG_PAGE) && (PADDR[1:0] == 2'b00);
  assign hit      = hit_ctrl || hit_stat || hit_cfg;
  assign cfg_idx  = PADDR[3:2];
  assign PREADY   = 1'b1;
  assign PSLVERR  = acc && !hit;

  assign status_word = (32'(drdy_cnt) << ST_CNT_LSB) | (32'(cur_ch) << ST_CH_LSB)
                     | (32'(phase) << ST_PH_LSB) | (32'(first) << ST_FIRST_BIT)
                     | (32'(dpp_busy) << ST_DPP_BIT);
  assign rd_mux = hit_ctrl ? (32'(run) << CTRL_RUN_BIT) :
                  hit_stat ? status_word :
                  hit_cfg  ? cfg[cfg_idx] : 32'h0000_0000;

  // Register writes in the access cycle, read data capture in the setup cycle
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      run    <= 1'b0;
      PRDATA <= 32'h0000_0000;
      for (int i = 0; i < NCH; i++) begin
        cfg[i] <= CFG_RESET;
      end
    end else begin
      if (setup) begin
        PRDATA <= rd_mux;
      end
      if (acc && PWRITE && hit_ctrl) begin
        run <= PWDATA[CTRL_RUN_BIT];
      end
      if (acc && PWRITE && hit_cfg) begin
        cfg[cfg_idx] <= PWDATA;
      end
    end
  end

  // Checking helpers: cycles since the last interval load
  logic [CNT_W-1:0] main_age;
  logic [CNT_W-1:0] dpp_age;
  logic [3:0]       dpp_ft;
  logic [FS_W-1:0]  dpp_fs;
  logic [SET_W-1:0] set_cur; // Settle code latched at channel start, immune to later writes

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      main_age <= '0;
      dpp_age  <= '0;
      dpp_ft   <= '0;
      dpp_fs   <= '0;
      set_cur  <= '0;
    end else begin
      main_age <= main_load ? CNT_W'(1) : main_age + CNT_W'(1);
      dpp_age  <= conv_done ? CNT_W'(1) : dpp_age + CNT_W'(1);
      if (conv_done) begin
        dpp_ft <= ft_cur;
        dpp_fs <= fs_cur;
      end
      if (chan_start) begin
        set_cur <= set_tgt;
      end
    end
  end

  // Assertions
  AST_SETTLE_MIN: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    settle_done |-> main_age >= CNT_W'(SETTLE_BASE)) else $error("settle shorter than minimum");
  AST_SETTLE_LEN: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    settle_done |-> main_age == (CNT_W'(SETTLE_BASE) << set_cur)) else $error("settle length wrong");
  AST_IDEAL_SINC4: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    conv_done && first && ft_cur == FT_SINC4 |-> main_age == CNT_W'(ORD_SINC4 * TCNV_MUL * int'(fs_cur)))
    else $error("sinc4 first conversion wrong");
  AST_IDEAL_SINC3: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    conv_done && first && (ft_cur == FT_SINC3 || ft_cur == FT_SINC3_R60)
      |-> main_age == CNT_W'(ORD_SINC3 * TCNV_MUL * int'(fs_cur)))
    else $error("sinc3 first conversion wrong");
  AST_IDEAL_AVG: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    conv_done && first && ft_cur == FT_SINC3_AVG
      |-> main_age == CNT_W'((ORD_SINC3 + AVG_LEN - 1) * TCNV_MUL * int'(fs_cur)))
    else $error("averaging first conversion wrong");
  AST_TCNV_AVG4: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    conv_done && !first && ft_cur == FT_SINC4_AVG
      |-> main_age == CNT_W'((ORD_SINC4 + AVG_LEN - 1) * TCNV_MUL * int'(fs_cur)))
    else $error("settled period wrong");
  AST_TCNV_POST: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    conv_done && ft_cur == FT_POST4 |-> main_age == CNT_W'(TCNV_POST4)) else $error("post period wrong");
  AST_DPP_SHORT: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    dpp_done && (dpp_ft == FT_SINC4 || dpp_ft == FT_SINC3 || dpp_ft == FT_SINC3_R60)
      && dpp_fs <= FS_W'(FS_SHORT_MAX) |-> dpp_age == CNT_W'(DPP_SHORT))
    else $error("short postprocess wrong");
  AST_DPP_POST: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    dpp_done && dpp_ft >= FT_POST1 |-> dpp_age == CNT_W'(DPP_POST)) else $error("post postprocess wrong");
  AST_SWITCH: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    conv_done && run && rep_left == '0 && nxt_ch != cur_ch |=> MOD_RESET && phase == PH_SETTLE
      && INPUT_CROSSPOINT_MUX == cur_ch) else $error("channel not switched");
  AST_DPP_OVERLAP: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    chan_switch |=> dpp_busy && phase == PH_SETTLE) else $error("switch waited on postprocess");
  AST_REPEAT: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    conv_done && run && en_vec[cur_ch] && rep_left != '0 |=> phase == PH_CONV && !first && !MOD_RESET)
    else $error("repeat conversion lost");
  AST_DRDY: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    dpp_done |=> DATA_READY && DATA_CH == $past(dpp_ch)) else $error("data ready missing");

  // Covers
  COV_REPEAT: cover property (@(posedge CORE_CLK) disable iff (!RST_N) stay && more_rep);
  COV_SWITCH: cover property (@(posedge CORE_CLK) disable iff (!RST_N) chan_switch && dpp_busy);
  COV_POST:   cover property (@(posedge CORE_CLK) disable iff (!RST_N) dpp_done && dpp_ft >= FT_POST1);
  COV_STOP:   cover property (@(posedge CORE_CLK) disable iff (!RST_N) stop);
endmodule

// >>> testbench/test_channel_sequencer_conv_timing.sv
// Self-checking testbench of the channel sequencer and conversion timer
`timescale 1ns/1ps
module test_channel_sequencer_conv_timing;
  import csq_pkg::*;
  // Design inputs
  logic           CORE_CLK = 1'b0;
  logic           RST_N    = 1'b0;
  logic           PSEL     = 1'b0;
  logic           PENABLE  = 1'b0;
  logic           PWRITE   = 1'b0;
  logic [7:0]     PADDR    = 8'h00;
  logic [31:0]    PWDATA   = 32'h0000_0000;
  // Design outputs
  logic [31:0]    PRDATA;
  logic           PREADY;
  logic           PSLVERR;
  logic           MOD_RESET;
  logic [CHW-1:0] INPUT_CROSSPOINT_MUX;
  logic           DATA_READY;
  logic [CHW-1:0] DATA_CH;
  // Bookkeeping
  int             fail_count = 0;
  int             n_tests    = 0;

  csq_sequencer dut_u (
    .CORE_CLK(CORE_CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .MOD_RESET(MOD_RESET), .INPUT_CROSSPOINT_MUX(INPUT_CROSSPOINT_MUX),
    .DATA_READY(DATA_READY), .DATA_CH(DATA_CH)
  );

  // 25 MHz main clock
  always #20 CORE_CLK = ~CORE_CLK;

  // Value comparison with counting
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One APB transfer: setup, then access until pready is seen
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int k;
    @(posedge CORE_CLK);
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= wd;
    @(posedge CORE_CLK);
    PENABLE <= 1'b1;
    k = 0;
    do begin
      @(posedge CORE_CLK);
      k++;
    end while (PREADY !== 1'b1 && k < 100);
    if (k >= 100) chk("pready wait", 32'h0000_0001, 32'h0000_0000);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  // Register write expecting no error, and register read compared with an expected value
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, a, d, rd, err);
    chk("write error", 32'h0000_0000, {31'h0, err});
  endtask

  task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, a, 32'h0000_0000, rd, err);
    chk(name, exp, rd);
  endtask

  // Count edges until a start pulse (0) or a result pulse (1) is seen
  task automatic wait_ev(input bit dr, output int n);
    n = 0;
    do begin
      @(posedge CORE_CLK);
      n++;
    end while (((dr ? DATA_READY : MOD_RESET) !== 1'b1) && n < 20000);
    if (n >= 20000) chk("event wait", 32'h0000_0001, 32'h0000_0000);
  endtask

  // Clear run and wait until phase and postprocess are idle
  task automatic stop_run();
    logic [31:0] rd;
    logic        err;
    int          k;
    wreg(OFF_CTRL, 32'h0000_0000);
    k = 0;
    do begin
      apb(1'b0, OFF_STATUS, 32'h0000_0000, rd, err);
      k++;
    end while (rd[21:18] !== 4'h0 && k < 3000);
    chk("idle after stop", 32'h0000_0000, {28'h0, rd[21:18]});
  endtask

  function automatic logic [31:0] cfg(logic [7:0] rep, logic [2:0] set, logic [3:0] ft, logic [10:0] fs);
    return {1'b1, 3'b000, rep, 1'b0, set, ft, 1'b0, fs};
  endfunction

  function automatic int tcnv_f(logic [3:0] ft, int fs);
    case (ft)
      FT_SINC4_AVG: return 352 * fs;
      FT_SINC3_AVG: return 320 * fs;
      FT_POST1:     return 2944;
      FT_POST2:     return 3200;
      FT_POST3:     return 3968;
      FT_POST4:     return 4736;
      default:      return 32 * fs;
    endcase
  endfunction

  function automatic int first_f(logic [3:0] ft, int fs, int code);
    int ideal;
    int digital_postprocess;
    ideal = (ft == FT_SINC4) ? 4 * tcnv_f(ft, fs) :
            (ft == FT_SINC3 || ft == FT_SINC3_R60) ? 3 * tcnv_f(ft, fs) : tcnv_f(ft, fs);
    digital_postprocess = (ft >= FT_POST1) ? 69 : (ft == FT_SINC4_AVG || ft == FT_SINC3_AVG || fs > 1) ? 62 : 28;
    return (32 << code) + ideal + digital_postprocess;
  endfunction

  // Reset values, read-back, read-only status and unmapped access
  task automatic t_regs();
    logic [31:0] rd;
    logic        err;
    rchk("ctrl reset", OFF_CTRL, 32'h0000_0000);
    rchk("status reset", OFF_STATUS, 32'h0000_0000);
    for (int i = 0; i < 4; i++) rchk("cfg reset", 8'h10 + 8'(4 * i), 32'h0000_0000);
    wreg(8'h14, 32'h7FFF_FFFF);
    rchk("cfg readback", 8'h14, 32'h7FFF_FFFF);
    wreg(8'h14, 32'h0000_0000);
    wreg(OFF_STATUS, 32'hFFFF_FFFF);
    rchk("status ro", OFF_STATUS, 32'h0000_0000);
    apb(1'b1, 8'h08, 32'hFFFF_FFFF, rd, err);
    chk("unmapped write err", 32'h0000_0001, {31'h0, err});
    apb(1'b0, 8'h08, 32'h0000_0000, rd, err);
    chk("unmapped read err", 32'h0000_0001, {31'h0, err});
    chk("unmapped read data", 32'h0000_0000, rd);
  endtask

  // Three channels, middle one repeating: order, mux, switch moments, spacing
  task automatic t_seq();
    int          mt[$];
    int          dt[$];
    logic [31:0] mc[$];
    logic [31:0] dc[$];
    int          c;
    wreg(8'h10, cfg(8'd0, 3'd0, FT_SINC4, 11'd1));
    wreg(8'h14, cfg(8'd2, 3'd0, FT_SINC4, 11'd1));
    wreg(8'h18, cfg(8'd0, 3'd0, FT_SINC4, 11'd1));
    wreg(OFF_CTRL, 32'h0000_0001);
    c = 0;
    while (dt.size() < 6 && c < 3000) begin
      @(posedge CORE_CLK);
      c++;
      if (MOD_RESET === 1'b1) mt.push_back(c);
      if (MOD_RESET === 1'b1) mc.push_back({30'h0, INPUT_CROSSPOINT_MUX});
      if (DATA_READY === 1'b1) dt.push_back(c);
      if (DATA_READY === 1'b1) dc.push_back({30'h0, DATA_CH});
    end
    chk("result count", 32'd6, 32'(dt.size()));
    chk("start count", 32'd1, {31'h0, mt.size() >= 3});
    if (dt.size() == 6 && mt.size() >= 3) begin
      chk("result ch 0", 32'd0, dc[0]);
      chk("result ch 1", 32'd1, dc[1]);
      chk("result ch 3", 32'd1, dc[3]);
      chk("result ch 4", 32'd2, dc[4]);
      chk("result ch 5", 32'd0, dc[5]);
      chk("mux ch0", 32'd0, mc[0]);
      chk("mux ch1", 32'd1, mc[1]);
      chk("mux ch2", 32'd2, mc[2]);
      chk("first result", 32'd188, 32'(dt[0] - mt[0]));
      chk("switch time", 32'd160, 32'(mt[1] - mt[0]));
      chk("repeat switch", 32'd224, 32'(mt[2] - mt[1]));
      chk("repeat spacing", 32'd32, 32'(dt[2] - dt[1]));
    end
    stop_run();
    wreg(8'h14, 32'h0000_0000);
    wreg(8'h18, 32'h0000_0000);
  endtask

  // Every filter type with a settle code from 0 to 7: first and settled interval
  task automatic t_filters();
    logic [3:0] ft;
    int         code;
    int         n;
    for (int i = 0; i < 9; i++) begin
      ft = 4'(i);
      code = (i + 7) % 8;
      wreg(8'h10, cfg(8'd3, 3'(code), ft, 11'd2));
      wreg(OFF_CTRL, 32'h0000_0001);
      wait_ev(1'b0, n);
      wait_ev(1'b1, n);
      chk("first conversion", 32'(first_f(ft, 2, code)), 32'(n));
      wait_ev(1'b1, n);
      chk("settled period", 32'(tcnv_f(ft, 2)), 32'(n));
      stop_run();
    end
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (16) @(posedge CORE_CLK);
    RST_N <= 1'b1;
    t_regs();
    t_seq();
    t_filters();
    wrap_up();
  end

  // Watchdog against a hang: the scenarios need about 65000 cycles
  initial begin
    repeat (90000) @(posedge CORE_CLK);
    fail_count++;
    wrap_up();
  end
endmodule
